// ### src/scc_pkg.sv
// constants and types for the smart card serial control block
`default_nettype none
package scc_pkg;
  // register byte offsets
  localparam logic [7:0] SCC_OFS_CTRL    = 8'h00;
  localparam logic [7:0] SCC_OFS_STAT    = 8'h04;
  localparam logic [7:0] SCC_OFS_TXD     = 8'h08;
  localparam logic [7:0] SCC_OFS_RXD     = 8'h0c;
  localparam logic [7:0] SCC_OFS_MODE    = 8'h10;
  localparam logic [7:0] SCC_OFS_IRQ_ST  = 8'h14;
  localparam logic [7:0] SCC_OFS_IRQ_MSK = 8'h18;
  // control bit positions
  localparam int SCC_CTL_TXIE = 7;
  localparam int SCC_CTL_RXIE = 6;
  localparam int SCC_CTL_TXON = 5;
  localparam int SCC_CTL_RXON = 4;
  // status bit positions
  localparam int SCC_ST_TXE = 7;
  localparam int SCC_ST_RXF = 6;
  localparam int SCC_ST_OVR = 5;
  localparam int SCC_ST_FRM = 4;
  localparam int SCC_ST_PAR = 3;
  localparam int SCC_ST_LO  = 3;
  // mode bit positions
  localparam int SCC_MODE_GSM = 0;
  localparam int SCC_MODE_ODD = 1;
  // interrupt status bit positions
  localparam int SCC_IRQ_TX  = 0;
  localparam int SCC_IRQ_RX  = 1;
  localparam int SCC_IRQ_ERR = 2;
  localparam int SCC_IRQ_W   = 3;
  // reset values
  localparam logic [7:0] SCC_CTRL_RST = 8'h00;
  localparam logic [7:0] SCC_STAT_RST = 8'h80;
  localparam logic [1:0] SCC_MODE_RST = 2'h0;
  // clock select codes
  localparam logic [1:0] SCC_CKS_OFF  = 2'h0;
  localparam logic [1:0] SCC_CKS_CLK  = 2'h1;
  localparam logic [1:0] SCC_CKS_HIGH = 2'h2;
  // character size
  localparam int SCC_DATA_BITS = 8;
  typedef enum logic [2:0] {SCC_IDLE, SCC_START, SCC_DATA, SCC_PARITY, SCC_STOP} scc_state_type;
  // parity bit for a character
  function automatic logic scc_parity(input logic [7:0] d, input logic odd);
    scc_parity = (^d) ^ odd;
  endfunction : scc_parity
endpackage : scc_pkg
`default_nettype wire

// ### src/scc_char_tx.sv
// character transmitter for the half-duplex card line
`default_nettype none
module scc_char_tx (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic       bit_tick,
  input  wire logic       load,
  input  wire logic [7:0] data,
  input  wire logic       odd,
  output logic            busy,
  // line
  output logic            line_out,
  output logic            line_oe
);
  import scc_pkg::*;
  scc_state_type state_r;
  logic [7:0]    shift_r;
  logic [2:0]    cnt_r;
  logic          par_r;

  // frame sequencer, one bit per tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= SCC_IDLE;
      shift_r <= 8'h00;
      cnt_r   <= 3'h0;
      par_r   <= 1'b0;
    end else begin
      case (state_r)
        SCC_IDLE: begin
          if (load) begin
            shift_r <= data;
            par_r   <= scc_parity(data, odd);
            state_r <= SCC_START;
          end
        end
        SCC_START: if (bit_tick) begin
          state_r <= SCC_DATA;
          cnt_r   <= 3'h0;
        end
        SCC_DATA: if (bit_tick) begin
          shift_r <= {1'b0, shift_r[7:1]};
          cnt_r   <= cnt_r + 3'h1;
          if (cnt_r == 3'(SCC_DATA_BITS - 1)) state_r <= SCC_PARITY;
        end
        SCC_PARITY: if (bit_tick) state_r <= SCC_STOP;
        SCC_STOP: if (bit_tick) state_r <= SCC_IDLE;
        default: state_r <= SCC_IDLE;
      endcase
    end
  end

  // line level per state; released while idle
  assign busy     = (state_r != SCC_IDLE);
  assign line_oe  = busy;
  assign line_out = (state_r == SCC_START) ? 1'b0 :
                    (state_r == SCC_DATA) ? shift_r[0] :
                    (state_r == SCC_PARITY) ? par_r : 1'b1;
endmodule : scc_char_tx
`default_nettype wire

// ### src/scc_char_rx.sv
// character receiver for the half-duplex card line
`default_nettype none
module scc_char_rx (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic       bit_tick,
  input  wire logic       enable,
  input  wire logic       line_in,
  input  wire logic       odd,
  // result
  output logic            done,
  output logic [7:0]      data,
  output logic            parity_err,
  output logic            frame_err
);
  import scc_pkg::*;
  scc_state_type state_r;
  logic [7:0]    shift_r;
  logic [2:0]    cnt_r;
  logic          done_r;
  logic          perr_r;
  logic          ferr_r;

  // start bit detect and bit sampling on ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= SCC_IDLE;
      shift_r <= 8'h00;
      cnt_r   <= 3'h0;
      done_r  <= 1'b0;
      perr_r  <= 1'b0;
      ferr_r  <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (!enable) begin
        state_r <= SCC_IDLE;
      end else if (bit_tick) begin
        case (state_r)
          SCC_IDLE: if (!line_in) begin
            state_r <= SCC_DATA;
            cnt_r   <= 3'h0;
          end
          SCC_DATA: begin
            shift_r <= {line_in, shift_r[7:1]};
            cnt_r   <= cnt_r + 3'h1;
            if (cnt_r == 3'(SCC_DATA_BITS - 1)) state_r <= SCC_PARITY;
          end
          SCC_PARITY: begin
            perr_r  <= (line_in != scc_parity(shift_r, odd));
            state_r <= SCC_STOP;
          end
          SCC_STOP: begin
            ferr_r  <= !line_in;
            done_r  <= 1'b1;
            state_r <= SCC_IDLE;
          end
          default: state_r <= SCC_IDLE;
        endcase
      end
    end
  end

  assign done       = done_r;
  assign data       = shift_r;
  assign parity_err = perr_r;
  assign frame_err  = ferr_r;
endmodule : scc_char_rx
`default_nettype wire

// ### src/scc_serial_ctrl.sv
// smart card serial control register with apb slave and line logic
`default_nettype none
module scc_serial_ctrl (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // link clock and card pins
  input  wire logic        link_clk,
  input  wire logic        data_in,
  output logic             data_out,
  output logic             data_oe,
  output logic             clk_pin_out,
  output logic             clk_pin_oe,
  // interrupt requests
  output logic             tx_empty_irq,
  output logic             rx_full_irq,
  output logic             rx_error_irq,
  output logic             irq
);
  import scc_pkg::*;

  logic [7:0]  ctrl_r;
  logic [7:3]  stat_r;
  logic [7:3]  armed_r;
  logic [7:0]  txd_r;
  logic [7:0]  rxd_r;
  logic [1:0]  mode_r;
  logic [2:0]  irq_st_r;
  logic [2:0]  irq_msk_r;
  logic [2:0]  req_d_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [2:0]  lclk_s_r;
  logic        lclk_lvl_r;
  logic [2:0]  din_s_r;
  logic        din_lvl_r;
  logic        clk_out_r;
  logic        clk_oe_r;

  // apb decode
  wire setup     = psel && !penable;
  wire access    = psel && penable && pready_r;
  wire wr        = access && pwrite;
  wire rd        = access && !pwrite;
  wire hit_ctrl  = (paddr == SCC_OFS_CTRL);
  wire hit_stat  = (paddr == SCC_OFS_STAT);
  wire hit_txd   = (paddr == SCC_OFS_TXD);
  wire hit_rxd   = (paddr == SCC_OFS_RXD);
  wire hit_mode  = (paddr == SCC_OFS_MODE);
  wire hit_ist   = (paddr == SCC_OFS_IRQ_ST);
  wire hit_msk   = (paddr == SCC_OFS_IRQ_MSK);
  wire mapped    = hit_ctrl | hit_stat | hit_txd | hit_rxd | hit_mode | hit_ist | hit_msk;
  wire [7:0] stat_view = {stat_r, 3'h0};
  wire [7:0] rd_mux = hit_ctrl ? ctrl_r : hit_stat ? stat_view : hit_txd ? txd_r :
                      hit_rxd ? rxd_r : hit_mode ? {6'h00, mode_r} :
                      hit_ist ? {5'h00, irq_st_r} : hit_msk ? {5'h00, irq_msk_r} : 8'h00;

  // control fields
  wire txie  = ctrl_r[SCC_CTL_TXIE];
  wire rxie  = ctrl_r[SCC_CTL_RXIE];
  wire txon  = ctrl_r[SCC_CTL_TXON];
  wire rxon  = ctrl_r[SCC_CTL_RXON];
  wire [1:0] cks = ctrl_r[1:0];
  wire gsm   = mode_r[SCC_MODE_GSM];
  wire odd   = mode_r[SCC_MODE_ODD];

  // link clock tick from the clean level
  wire lclk_stable = (lclk_s_r[1] == lclk_s_r[2]);
  wire din_stable  = (din_s_r[1] == din_s_r[2]);
  wire bit_tick    = lclk_stable && lclk_s_r[2] && !lclk_lvl_r;

  // transmitter and receiver
  logic       tx_busy;
  logic       rx_done;
  logic [7:0] rx_data;
  logic       rx_perr;
  logic       rx_ferr;
  // load only when enabled and flag cleared
  wire tx_load = txon && !stat_r[SCC_ST_TXE] && !tx_busy;

  scc_char_tx u_tx (
    .pclk     (pclk),
    .presetn  (presetn),
    .bit_tick (bit_tick),
    .load     (tx_load),
    .data     (txd_r),
    .odd      (odd),
    .busy     (tx_busy),
    .line_out (data_out),
    .line_oe  (data_oe)
  );

  scc_char_rx u_rx (
    .pclk       (pclk),
    .presetn    (presetn),
    .bit_tick   (bit_tick),
    .enable     (rxon),
    .line_in    (din_lvl_r),
    .odd        (odd),
    .done       (rx_done),
    .data       (rx_data),
    .parity_err (rx_perr),
    .frame_err  (rx_ferr)
  );

  // zero written after a read of one clears
  wire [7:3] clr_ok = (wr && hit_stat) ? (armed_r & ~pwdata[7:3]) : 5'h00;
  wire rx_ok   = rx_done && !stat_r[SCC_ST_RXF];
  wire rx_ovr  = rx_done && stat_r[SCC_ST_RXF];
  wire [7:3] set_ev = {tx_load || !txon, rx_ok, rx_ovr, rx_ok && rx_ferr, rx_ok && rx_perr};
  wire [7:3] stat_nxt = set_ev | (stat_r & ~clr_ok);

  assign tx_empty_irq = txie && stat_r[SCC_ST_TXE];
  assign rx_full_irq  = rxie && stat_r[SCC_ST_RXF];
  assign rx_error_irq = rxie && (stat_r[SCC_ST_OVR] || stat_r[SCC_ST_FRM] || stat_r[SCC_ST_PAR]);
  wire [2:0] req_now  = {rx_error_irq, rx_full_irq, tx_empty_irq};
  wire [2:0] irq_nxt  = (req_now & ~req_d_r) | (irq_st_r & ~((wr && hit_ist) ? pwdata[2:0] : 3'h0));
  assign irq = |(irq_st_r & irq_msk_r);

  // clock pin select, registered, follows control one cycle later
  wire pin_clk = gsm ? cks[0] : (cks == SCC_CKS_CLK);
  wire pin_lvl = pin_clk ? lclk_lvl_r : (gsm && cks == SCC_CKS_HIGH);
  wire pin_oe  = gsm || (cks == SCC_CKS_CLK);

  // apb answer, one access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup && !mapped;
      if (setup) prdata_r <= {24'h00_0000, rd_mux};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_r <= SCC_CTRL_RST;
    else if (wr && hit_ctrl) ctrl_r <= pwdata[7:0];
  end

  // status flags, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r  <= SCC_STAT_RST[7:3];
      armed_r <= 5'h00;
    end else begin
      stat_r  <= stat_nxt;
      if (rd && hit_stat) armed_r <= stat_r;
      else armed_r <= armed_r & ~clr_ok;
    end
  end

  // data, mode and interrupt registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_r     <= 8'h00;
      rxd_r     <= 8'h00;
      mode_r    <= SCC_MODE_RST;
      irq_st_r  <= 3'h0;
      irq_msk_r <= 3'h0;
      req_d_r   <= 3'h0;
    end else begin
      if (wr && hit_txd) txd_r <= pwdata[7:0];
      if (rx_ok) rxd_r <= rx_data;
      if (wr && hit_mode) mode_r <= pwdata[1:0];
      if (wr && hit_msk) irq_msk_r <= pwdata[2:0];
      irq_st_r <= irq_nxt;
      req_d_r  <= req_now;
    end
  end

  // three-stage synchronisers and clean levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lclk_s_r   <= 3'h0;
      lclk_lvl_r <= 1'b0;
      din_s_r    <= 3'h7;
      din_lvl_r  <= 1'b1;
    end else begin
      lclk_s_r <= {lclk_s_r[1:0], link_clk};
      din_s_r  <= {din_s_r[1:0], data_in};
      if (lclk_stable) lclk_lvl_r <= lclk_s_r[2];
      if (din_stable) din_lvl_r <= din_s_r[2];
    end
  end

  // clock pin output flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_out_r <= 1'b0;
      clk_oe_r  <= 1'b0;
    end else begin
      clk_out_r <= pin_lvl;
      clk_oe_r  <= pin_oe;
    end
  end

  assign prdata      = prdata_r;
  assign pready      = pready_r;
  assign pslverr     = pslverr_r;
  assign clk_pin_out = clk_out_r;
  assign clk_pin_oe  = clk_oe_r;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // apb answer one cycle after setup
  apb_ready_a: assert property (setup |=> pready) else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held high");
  unmapped_err_a: assert property (setup && !mapped |=> pslverr) else $error("no slave error");

  tx_irq_gate_a: assert property (tx_empty_irq == (txie && stat_r[SCC_ST_TXE])) else $error("tx irq gate");
  tx_irq_drop_a: assert property ($fell(txie) |-> !tx_empty_irq) else $error("tx irq kept");

  rx_irq_gate_a: assert property (!rxie |-> !rx_full_irq && !rx_error_irq) else $error("rx irq gate");
  rx_full_req_a: assert property (rxie && stat_r[SCC_ST_RXF] |-> rx_full_irq) else $error("rx irq missing");
  rx_irq_drop_a: assert property ($fell(rxie) |-> !rx_full_irq && !rx_error_irq) else $error("rx irq kept");
  rx_clear_a: assert property ($fell(stat_r[SCC_ST_RXF]) |->
    $past(wr && hit_stat && armed_r[SCC_ST_RXF])) else $error("bad rx clear");

  te_off_empty_a: assert property (!txon |=> stat_r[SCC_ST_TXE]) else $error("tx-empty not forced");
  tx_off_idle_a: assert property (!txon && !tx_busy |=> !tx_busy) else $error("tx while off");
  tx_on_start_a: assert property ($rose(data_oe) |-> $past(txon)) else $error("line driven while off");
  tx_start_a: assert property ($rose(tx_busy) |->
    $past(txon) && !$past(stat_r[SCC_ST_TXE])) else $error("bad start");
  load_sets_empty_a: assert property (tx_load |=> stat_r[SCC_ST_TXE]) else $error("tx-empty not set");
  empty_clear_a: assert property ($fell(stat_r[SCC_ST_TXE]) |->
    $past(wr && hit_stat && armed_r[SCC_ST_TXE])) else $error("bad clear");

  rx_store_a: assert property (rx_ok |=> rxd_r == $past(rx_data)) else $error("rx data not stored");
  rx_off_done_a: assert property (!rxon |=> !rx_done) else $error("rx while off");
  rx_flags_hold_a: assert property (!rxon && !rx_done && !(wr && hit_stat) |=>
    $stable(stat_r[6:3])) else $error("flags moved");

  // overrun keeps the stored character
  overrun_keep_a: assert property (rx_ovr |=> $stable(rxd_r)) else $error("overrun overwrote data");

  // interrupt status catches each request rise
  irq_tx_set_a: assert property ($rose(tx_empty_irq) |=> irq_st_r[SCC_IRQ_TX]) else $error("tx event lost");
  irq_rx_set_a: assert property ($rose(rx_full_irq) |=> irq_st_r[SCC_IRQ_RX]) else $error("rx event lost");
  irq_err_set_a: assert property ($rose(rx_error_irq) |=> irq_st_r[SCC_IRQ_ERR]) else $error("err event lost");

  port_mode_a: assert property (!gsm && cks == SCC_CKS_OFF |=> !clk_pin_oe) else $error("port mode");
  reserved_off_a: assert property (!gsm && cks[1] |=> !clk_pin_oe) else $error("reserved drives pin");
  plain_clock_a: assert property (!gsm && cks == SCC_CKS_CLK |=>
    clk_pin_oe && clk_pin_out == $past(lclk_lvl_r)) else $error("no clock out");
  gsm_low_a: assert property (gsm && cks == SCC_CKS_OFF |=>
    clk_pin_oe && !clk_pin_out) else $error("gsm low");
  gsm_high_a: assert property (gsm && cks == SCC_CKS_HIGH |=>
    clk_pin_oe && clk_pin_out) else $error("gsm high");
  gsm_clock_a: assert property (gsm && cks[0] |=>
    clk_pin_oe && clk_pin_out == $past(lclk_lvl_r)) else $error("gsm no clock");

  ctrl_write_a: assert property (wr && hit_ctrl |=> ctrl_r == $past(pwdata[7:0])) else $error("ctrl write");
  ctrl_hold_a: assert property (!(wr && hit_ctrl) |=> $stable(ctrl_r)) else $error("ctrl moved");

  // main scenarios reached
  tx_char_c: cover property ($fell(tx_busy));
  rx_char_c: cover property (rx_ok);
  overrun_c: cover property (rx_ovr);
  gsm_high_c: cover property (gsm && cks == SCC_CKS_HIGH && clk_pin_out);
  rx_error_c: cover property (rx_ok && rx_perr);
endmodule : scc_serial_ctrl
`default_nettype wire

// ### test/scc_card_model.sv
// smart card model: clocks the link, sends and captures characters
`default_nettype none
module scc_card_model (
  // line and device drive
  input  wire logic       line,
  input  wire logic       dev_oe,
  // bench control
  input  wire logic       send,
  input  wire logic [7:0] send_byte,
  input  wire logic       bad_par,
  // link clock and card drive
  output logic            link_clk,
  output logic            card_out,
  output logic            card_oe,
  // captured device frame
  output logic [10:0]     frame,
  output logic [3:0]      done_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [10:0] bits;
  initial begin
    link_clk = 1'b0;
    card_out = 1'b1;
    card_oe  = 1'b0;
    frame    = '0;
    done_cnt = '0;
  end
  // link clock runs only inside a frame, idle low
  always begin
    @(posedge dev_oe or posedge send);
    if (send) begin
      // start bit, lsb first data, parity, stop
      bits    = {1'b1, (^send_byte) ^ bad_par, send_byte, 1'b0};
      card_oe = 1'b1;
      for (int i = 0; i < 11; i++) begin
        card_out = bits[i];
        #16 link_clk = 1'b1;
        #32 link_clk = 1'b0;
        #16;
      end
      card_oe  = 1'b0;
      card_out = 1'b1;
    end else begin
      // capture once the device starts driving
      for (int i = 0; i < 11; i++) begin
        #15 bits[i] = line;
        #1 link_clk = 1'b1;
        #32 link_clk = 1'b0;
        #16;
      end
      // extra ticks until the device lets go
      for (int i = 0; i < 3 && dev_oe; i++) begin
        #16 link_clk = 1'b1;
        #32 link_clk = 1'b0;
        #16;
      end
      frame = bits;
    end
    done_cnt = done_cnt + 4'h1;
  end
endmodule : scc_card_model
`default_nettype wire

// ### test/scc_serial_ctrl_tb.sv
// self-checking testbench for the smart card serial control block
`default_nettype none
module scc_serial_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import scc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, send_byte;
  logic [31:0] pwdata, prdata, rd;
  logic        link_clk, data_out, data_oe, clk_pin_out, clk_pin_oe, irq;
  logic        tx_empty_irq, rx_full_irq, rx_error_irq, card_out, card_oe, send, bad_par;
  logic [10:0] frame;
  logic [3:0]  done_cnt, cnt0;
  int          num_errors, num_checks;
  // card line with pull-up when nobody drives
  wire logic line = data_oe ? data_out : (card_oe ? card_out : 1'b1);

  scc_serial_ctrl u_scc_serial_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_clk(link_clk), .data_in(line), .data_out(data_out), .data_oe(data_oe), .clk_pin_out(clk_pin_out),
    .clk_pin_oe(clk_pin_oe), .tx_empty_irq(tx_empty_irq), .rx_full_irq(rx_full_irq),
    .rx_error_irq(rx_error_irq), .irq(irq));
  scc_card_model u_scc_card_model (.line(line), .dev_oe(data_oe), .send(send), .send_byte(send_byte),
    .bad_par(bad_par), .link_clk(link_clk), .card_out(card_out), .card_oe(card_oe), .frame(frame),
    .done_cnt(done_cnt));

  always #4 pclk = ~pclk;

  task automatic stop_test();
    if (num_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, request held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      num_errors++;
      stop_test();
    end
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  task automatic settle();
    repeat (4) @(posedge pclk);
    #1;
  endtask : settle
  task automatic wait_frame();
    for (int n = 0; n < 3000 && done_cnt === cnt0; n++) @(posedge pclk);
    if (done_cnt === cnt0) begin
      num_errors++;
      stop_test();
    end
  endtask : wait_frame
  // send a character and check what the card saw on the line
  task automatic tx_char(input logic [7:0] d, input logic odd);
    cnt0 = done_cnt;
    wr(SCC_OFS_TXD, d);
    rdchk(SCC_OFS_STAT, 32'h80);
    wr(SCC_OFS_STAT, 8'h7f);
    wait_frame();
    chk({21'h0, frame}, {21'h0, 1'b1, (^d) ^ odd, d, 1'b0});
  endtask : tx_char
  task automatic card_send(input logic [7:0] d, input logic bad);
    cnt0 = done_cnt;
    send_byte <= d;
    bad_par   <= bad;
    send      <= 1'b1;
    wait_frame();
    send <= 1'b0;
    settle();
  endtask : card_send
  function automatic logic [1:0] pin_exp(input int g, input int c);
    if (g == 0)
      return (c == 1) ? 2'b10 : 2'b00;
    return (c == 2) ? 2'b11 : 2'b10;
  endfunction : pin_exp

  // hang guard
  initial begin
    #400000;
    num_errors++;
    stop_test();
  end
  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, send, bad_par} = '0;
    paddr = '0;
    pwdata = '0;
    send_byte = '0;
    num_errors = 0;
    num_checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, read-write bits, unmapped place
    rdchk(SCC_OFS_CTRL, 32'h00);
    rdchk(SCC_OFS_STAT, 32'h80);
    apb(1'b0, 8'h1c, 32'h0);
    chk(rd, 32'h0);
    chk(32'(err), 32'h1);
    wr(SCC_OFS_CTRL, 8'hf3);
    rdchk(SCC_OFS_CTRL, 32'hf3);
    // clock pin codes in both modes, switched while running
    for (int g = 0; g < 2; g++) begin
      wr(SCC_OFS_MODE, g[7:0]);
      for (int c = 0; c < 4; c++) begin
        wr(SCC_OFS_CTRL, c[7:0]);
        settle();
        chk(32'({clk_pin_oe, clk_pin_oe & clk_pin_out}), 32'(pin_exp(g, c)));
      end
    end
    // transmit path and interrupt status, mask, clear
    wr(SCC_OFS_MODE, 8'h00);
    wr(SCC_OFS_IRQ_MSK, 8'h01);
    wr(SCC_OFS_CTRL, 8'ha0);
    settle();
    chk(32'(tx_empty_irq), 32'h1);
    chk(32'(irq), 32'h1);
    rdchk(SCC_OFS_IRQ_ST, 32'h1);
    wr(SCC_OFS_IRQ_ST, 8'h01);
    settle();
    chk(32'(irq), 32'h0);
    wr(SCC_OFS_CTRL, 8'h20);
    settle();
    chk(32'(tx_empty_irq), 32'h0);
    wr(SCC_OFS_CTRL, 8'ha0);
    tx_char(8'ha5, 1'b0);
    wr(SCC_OFS_MODE, 8'h02);
    tx_char(8'h01, 1'b1);
    // transmitter off: flag pinned, line quiet
    wr(SCC_OFS_CTRL, 8'h80);
    wr(SCC_OFS_TXD, 8'h33);
    rdchk(SCC_OFS_STAT, 32'h80);
    wr(SCC_OFS_STAT, 8'h7f);
    settle();
    rdchk(SCC_OFS_STAT, 32'h80);
    chk(32'(data_oe), 32'h0);
    // receive path, error, enables cleared
    wr(SCC_OFS_MODE, 8'h00);
    wr(SCC_OFS_CTRL, 8'h50);
    card_send(8'h5a, 1'b0);
    chk(32'(rx_full_irq), 32'h1);
    rdchk(SCC_OFS_STAT, 32'hc0);
    rdchk(SCC_OFS_RXD, 32'h5a);
    wr(SCC_OFS_STAT, 8'hbf);
    settle();
    chk(32'(rx_full_irq), 32'h0);
    card_send(8'h5a, 1'b1);
    chk(32'(rx_error_irq), 32'h1);
    // overrun: full flag still set, new character dropped
    card_send(8'h3c, 1'b0);
    rdchk(SCC_OFS_STAT, 32'he8);
    rdchk(SCC_OFS_RXD, 32'h5a);
    wr(SCC_OFS_CTRL, 8'h10);
    settle();
    chk(32'(rx_error_irq), 32'h0);
    wr(SCC_OFS_CTRL, 8'h00);
    apb(1'b0, SCC_OFS_STAT, 32'h0);
    chk(rd, 32'he8);
    stop_test();
  end
endmodule : scc_serial_ctrl_tb
`default_nettype wire
